// ==== ecl_defines.svh ====
// Purpose: constants of the configuration image loader
// Assumes: byte-wide image memory reached through an external serial reader
// Notes: included by the loader, which holds the register slave
//
// What this block does
// - common flag: one setting set for all channels
// - optional CRC over headers and data
// - up to sixteen devices share one image
// - image opens with three-byte base header
// - per-device map header: CRC and start address
// - small image: 8-byte map header, 66-byte slot
// - large image: 12-byte map header, 66-byte slot
// - each slot is one register setting set
`ifndef ECL_DEFINES_SVH
`define ECL_DEFINES_SVH
`define ECL_BASE_LEN 10'h003
`define ECL_MAP_LEN_SMALL 10'h008
`define ECL_MAP_LEN_LARGE 10'h00c
`define ECL_SLOT_LEN 7'h42
`define ECL_SLOT_LAST 7'h41
`define ECL_NUM_CHAN 3'h4
`define ECL_BIT_CRC_EN 7
`define ECL_BIT_MAP_EN 6
`define ECL_BIT_LARGE 5
`define ECL_BIT_COMMON 0
`define ECL_CRC_POLY 8'h07
`define ECL_CRC_INIT 8'hff
`define ECL_REG_CTRL 4'h0
`define ECL_REG_STATUS 4'h4
`define ECL_REG_CRC 4'h8
`define ECL_REG_START 4'hc
`define ECL_WORD_W 20
`define ECL_FIFO_D 16
`endif

// ==== ecl_fifo.sv ====
// Purpose: small synchronous FIFO with valid/ready on both sides
// Assumes: one clock
// Notes: full and empty follow the occupancy count
`timescale 1ns/1ps
module ecl_fifo #(
  parameter int WIDTH = 20,
  parameter int DEPTH = 16
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_r;
  logic [AW-1:0] rd_r;
  logic [AW:0] cnt_r;
  logic push;
  logic pop;

  assign o_in_ready = (cnt_r != (AW+1)'(DEPTH));
  assign o_out_valid = (cnt_r != '0);
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;
  assign o_out_data = mem[rd_r];

  always_ff @(posedge i_clk)
  begin
    if (push)
    begin
      mem[wr_r] <= i_in_data;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_r <= (wr_r == AW'(DEPTH - 1)) ? '0 : wr_r + 1'b1;
      end
      if (pop)
      begin
        rd_r <= (rd_r == AW'(DEPTH - 1)) ? '0 : rd_r + 1'b1;
      end
      if (push && !pop)
      begin
        cnt_r <= cnt_r + 1'b1;
      end
      else if (pop && !push)
      begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end
endmodule

// ==== ecl_loader.sv ====
// Purpose: walks the configuration image and streams register writes
// Assumes: a serial reader on i_clk returns one image byte per request
// Notes: with CRC and map header on, the data is read twice: check pass, then load pass
//
// Added by the designer: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "ecl_defines.svh"
module ecl_loader (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [3:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  output logic o_rd_req,
  output logic [9:0] o_rd_addr,
  input wire logic i_rd_valid,
  input wire logic [7:0] i_rd_data,
  output logic o_cfg_valid,
  input wire logic i_cfg_ready,
  output logic [3:0] o_cfg_chan,
  output logic [7:0] o_cfg_addr,
  output logic [7:0] o_cfg_data
);
  ecl_pkg::ecl_state_type state_r;
  logic [3:0] dev_idx_r;
  logic start_r;
  logic crc_en_r;
  logic map_en_r;
  logic large_r;
  logic common_r;
  logic [3:0] dev_cnt_r;
  logic [7:0] burst_r;
  logic [9:0] addr_r;
  logic [9:0] bidx_r;
  logic [6:0] sidx_r;
  logic [1:0] slot_r;
  logic [7:0] crc_r;
  logic [7:0] crc_nxt;
  logic [7:0] crc_exp_r;
  logic [9:0] start_addr_r;
  logic [7:0] pair_addr_r;
  logic done_r;
  logic crc_err_r;
  logic idx_err_r;
  logic ack_r;
  logic [31:0] rdat_r;
  logic wb_hit;
  logic wb_wr;
  logic fifo_in_ready;
  logic fifo_in_valid;
  logic [`ECL_WORD_W-1:0] fifo_out;
  logic [9:0] map_len;
  logic [1:0] last_slot;
  logic data_end;
  logic busy;
  logic byte_in;
  logic [3:0] chan_mask;

  assign wb_hit = i_wb_cyc && i_wb_stb && !ack_r;
  // writes land on the edge at which the master sees ack
  assign wb_wr = i_wb_cyc && i_wb_stb && i_wb_we && ack_r;
  assign o_wb_ack = ack_r;
  assign o_wb_dat = rdat_r;
  assign busy = (state_r == ecl_pkg::ECL_BASE) || (state_r == ecl_pkg::ECL_MAP)
             || (state_r == ecl_pkg::ECL_CHK) || (state_r == ecl_pkg::ECL_LOAD);
  assign byte_in = o_rd_req && i_rd_valid;
  assign map_len = large_r ? `ECL_MAP_LEN_LARGE : `ECL_MAP_LEN_SMALL;
  assign last_slot = common_r ? 2'h0 : 2'(`ECL_NUM_CHAN - 3'h1);
  assign data_end = (sidx_r == `ECL_SLOT_LAST) && (slot_r == last_slot);
  assign chan_mask = common_r ? 4'hf : (4'h1 << slot_r);

  // crc-8 over one image byte
  always_comb
  begin
    crc_nxt = crc_r ^ i_rd_data;
    for (int k = 0; k < 8; k++)
    begin
      crc_nxt = crc_nxt[7] ? ((crc_nxt << 1) ^ `ECL_CRC_POLY) : (crc_nxt << 1);
    end
  end

  // wishbone slave: one wait state, answer in the cycle after the strobe
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      ack_r <= 1'b0;
    end
    else
    begin
      ack_r <= wb_hit;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      rdat_r <= 32'h0;
    end
    else if (wb_hit && !i_wb_we)
    begin
      unique case (i_wb_adr)
        `ECL_REG_CTRL: rdat_r <= {24'h0, dev_idx_r, 4'h0};
        `ECL_REG_STATUS: rdat_r <= {12'h0, burst_r, dev_cnt_r, 1'b0, crc_en_r,
                                    large_r, common_r, idx_err_r, crc_err_r,
                                    done_r, busy};
        `ECL_REG_CRC: rdat_r <= {16'h0, crc_r, crc_exp_r};
        `ECL_REG_START: rdat_r <= {22'h0, start_addr_r};
        default: rdat_r <= 32'h0;
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      dev_idx_r <= 4'h0;
      start_r <= 1'b0;
    end
    else
    begin
      start_r <= 1'b0;
      if (wb_wr && (i_wb_adr == `ECL_REG_CTRL) && i_wb_sel[0])
      begin
        dev_idx_r <= i_wb_dat[7:4];
        start_r <= i_wb_dat[0];
      end
    end
  end

  // image byte requests; the load pass stalls while the FIFO is full
  always_comb
  begin
    o_rd_req = 1'b0;
    if ((state_r == ecl_pkg::ECL_BASE) || (state_r == ecl_pkg::ECL_MAP)
        || (state_r == ecl_pkg::ECL_CHK))
    begin
      o_rd_req = 1'b1;
    end
    else if (state_r == ecl_pkg::ECL_LOAD)
    begin
      o_rd_req = fifo_in_ready;
    end
  end
  assign o_rd_addr = addr_r;

  // main walk through the image
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      state_r <= ecl_pkg::ECL_IDLE;
      addr_r <= 10'h0;
      bidx_r <= 10'h0;
      sidx_r <= 7'h0;
      slot_r <= 2'h0;
    end
    else
    begin
      unique case (state_r)
        ecl_pkg::ECL_IDLE, ecl_pkg::ECL_DONE, ecl_pkg::ECL_ERR:
        begin
          if (start_r)
          begin
            state_r <= ecl_pkg::ECL_BASE;
            addr_r <= 10'h0;
            bidx_r <= 10'h0;
          end
        end
        ecl_pkg::ECL_BASE:
        begin
          if (byte_in)
          begin
            bidx_r <= bidx_r + 10'h1;
            addr_r <= addr_r + 10'h1;
            if (bidx_r == `ECL_BASE_LEN - 10'h1)
            begin
              bidx_r <= 10'h0;
              sidx_r <= 7'h0;
              slot_r <= 2'h0;
              if (dev_idx_r > dev_cnt_r)
              begin
                state_r <= ecl_pkg::ECL_ERR;
              end
              else if (map_en_r)
              begin
                state_r <= ecl_pkg::ECL_MAP;
                addr_r <= `ECL_BASE_LEN + 10'(dev_idx_r) * map_len;
              end
              else
              begin
                state_r <= ecl_pkg::ECL_LOAD;
                addr_r <= `ECL_BASE_LEN;
              end
            end
          end
        end
        ecl_pkg::ECL_MAP:
        begin
          if (byte_in)
          begin
            bidx_r <= bidx_r + 10'h1;
            addr_r <= addr_r + 10'h1;
            if (bidx_r == map_len - 10'h1)
            begin
              addr_r <= start_addr_r;
              state_r <= crc_en_r ? ecl_pkg::ECL_CHK : ecl_pkg::ECL_LOAD;
            end
          end
        end
        ecl_pkg::ECL_CHK, ecl_pkg::ECL_LOAD:
        begin
          if (byte_in)
          begin
            addr_r <= addr_r + 10'h1;
            sidx_r <= sidx_r + 7'h1;
            if (sidx_r == `ECL_SLOT_LAST)
            begin
              sidx_r <= 7'h0;
              slot_r <= slot_r + 2'h1;
            end
            if (data_end)
            begin
              sidx_r <= 7'h0;
              slot_r <= 2'h0;
              addr_r <= start_addr_r;
              if (state_r == ecl_pkg::ECL_LOAD)
              begin
                state_r <= ecl_pkg::ECL_DONE;
              end
              else if (crc_nxt != crc_exp_r)
              begin
                state_r <= ecl_pkg::ECL_ERR;
              end
              else
              begin
                state_r <= ecl_pkg::ECL_LOAD;
              end
            end
          end
        end
        default:
        begin
          state_r <= ecl_pkg::ECL_IDLE;
        end
      endcase
    end
  end

  // base header fields
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      crc_en_r <= 1'b0;
      map_en_r <= 1'b0;
      large_r <= 1'b0;
      dev_cnt_r <= 4'h0;
      burst_r <= 8'h0;
      common_r <= 1'b0;
    end
    else if ((state_r == ecl_pkg::ECL_BASE) && byte_in)
    begin
      unique case (bidx_r[1:0])
        2'h0:
        begin
          crc_en_r <= i_rd_data[`ECL_BIT_CRC_EN];
          map_en_r <= i_rd_data[`ECL_BIT_MAP_EN];
          large_r <= i_rd_data[`ECL_BIT_LARGE];
          dev_cnt_r <= i_rd_data[3:0];
        end
        2'h1:
        begin
          burst_r <= i_rd_data;
        end
        default:
        begin
          common_r <= i_rd_data[`ECL_BIT_COMMON];
        end
      endcase
    end
  end

  // own address map header: expected crc and data start
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      crc_exp_r <= 8'h0;
      start_addr_r <= 10'h0;
    end
    else if ((state_r == ecl_pkg::ECL_BASE) && byte_in)
    begin
      start_addr_r <= `ECL_BASE_LEN;
    end
    else if ((state_r == ecl_pkg::ECL_MAP) && byte_in)
    begin
      if (bidx_r == 10'h0)
      begin
        crc_exp_r <= i_rd_data;
      end
      else if (large_r && (bidx_r == 10'h1))
      begin
        start_addr_r <= {i_rd_data[1:0], 8'h0};
      end
      else if (large_r && (bidx_r == 10'h2))
      begin
        start_addr_r <= {start_addr_r[9:8], i_rd_data};
      end
      else if (!large_r && (bidx_r == 10'h1))
      begin
        start_addr_r <= {2'h0, i_rd_data};
      end
    end
  end

  // crc runs over base header, own map header (not its crc byte) and data
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      crc_r <= `ECL_CRC_INIT;
    end
    else if (start_r && !busy)
    begin
      crc_r <= `ECL_CRC_INIT;
    end
    else if (byte_in && (state_r == ecl_pkg::ECL_BASE))
    begin
      // base bytes always count: the enable flag is still arriving here
      crc_r <= crc_nxt;
    end
    else if (byte_in && crc_en_r)
    begin
      if ((state_r == ecl_pkg::ECL_MAP) && (bidx_r != 10'h0))
      begin
        crc_r <= crc_nxt;
      end
      else if (state_r == ecl_pkg::ECL_CHK)
      begin
        crc_r <= crc_nxt;
      end
    end
  end

  // status flags; cleared by a new start, which is only taken when idle
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      done_r <= 1'b0;
      crc_err_r <= 1'b0;
      idx_err_r <= 1'b0;
    end
    else if (start_r && !busy)
    begin
      done_r <= 1'b0;
      crc_err_r <= 1'b0;
      idx_err_r <= 1'b0;
    end
    else if (byte_in)
    begin
      if ((state_r == ecl_pkg::ECL_LOAD) && data_end)
      begin
        done_r <= 1'b1;
      end
      if ((state_r == ecl_pkg::ECL_CHK) && data_end && (crc_nxt != crc_exp_r))
      begin
        crc_err_r <= 1'b1;
      end
      if ((state_r == ecl_pkg::ECL_BASE) && (bidx_r == `ECL_BASE_LEN - 10'h1)
          && (dev_idx_r > dev_cnt_r))
      begin
        idx_err_r <= 1'b1;
      end
    end
  end

  // slot bytes pair up as register address then value
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      pair_addr_r <= 8'h0;
    end
    else if ((state_r == ecl_pkg::ECL_LOAD) && byte_in && !sidx_r[0])
    begin
      pair_addr_r <= i_rd_data;
    end
  end

  assign fifo_in_valid = (state_r == ecl_pkg::ECL_LOAD) && byte_in && sidx_r[0];

  ecl_fifo #(
    .WIDTH(`ECL_WORD_W),
    .DEPTH(`ECL_FIFO_D)
  ) u_fifo (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_in_valid(fifo_in_valid),
    .o_in_ready(fifo_in_ready),
    .i_in_data({chan_mask, pair_addr_r, i_rd_data}),
    .o_out_valid(o_cfg_valid),
    .i_out_ready(i_cfg_ready),
    .o_out_data(fifo_out)
  );

  assign o_cfg_chan = fifo_out[19:16];
  assign o_cfg_addr = fifo_out[15:8];
  assign o_cfg_data = fifo_out[7:0];
endmodule

// ==== ecl_loader_checker.sv ====
// Purpose: port checker for the image loader
// Assumes: one clock, async active-high reset
// Notes: bound from the testbench top file
`timescale 1ns/1ps
module ecl_loader_checker (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [3:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  input wire logic [31:0] o_wb_dat,
  input wire logic o_wb_ack,
  input wire logic o_rd_req,
  input wire logic [9:0] o_rd_addr,
  input wire logic i_rd_valid,
  input wire logic [7:0] i_rd_data,
  input wire logic o_cfg_valid,
  input wire logic i_cfg_ready,
  input wire logic [3:0] o_cfg_chan,
  input wire logic [7:0] o_cfg_addr,
  input wire logic [7:0] o_cfg_data
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  ack_after_req_a: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
    else $error("no ack one cycle after request");
  ack_one_cycle_a: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack held too long");
  ack_has_req_a: assert property (o_wb_ack |-> $past(i_wb_cyc && i_wb_stb))
    else $error("ack without request");
  start_base_a: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack && i_wb_we
    && i_wb_adr == 4'h0 && i_wb_sel[0] && i_wb_dat[0] && !o_rd_req && !o_cfg_valid
    |-> ##[1:3] (o_rd_req && o_rd_addr == 10'h000)) else $error("load not opened at byte 0");
  base_order_a: assert property (o_rd_req && i_rd_valid && o_rd_addr < 10'h002
    |=> o_rd_addr == $past(o_rd_addr) + 10'h001) else $error("base header out of order");
  addr_hold_a: assert property (o_rd_req && !i_rd_valid |=> $stable(o_rd_addr))
    else $error("read address moved while waiting");
  word_hold_a: assert property (o_cfg_valid && !i_cfg_ready
    |=> o_cfg_valid && $stable({o_cfg_chan, o_cfg_addr, o_cfg_data}))
    else $error("config word dropped or changed");
  chan_mask_a: assert property (o_cfg_valid
    |-> o_cfg_chan inside {4'h1, 4'h2, 4'h4, 4'h8, 4'hf}) else $error("bad channel mask");
endmodule

// ==== ecl_mem_model.sv ====
// Purpose: image memory answering one byte read at a time
// Assumes: one request outstanding
// Notes: i_lat sets answer delay; data line toggles outside answers
`timescale 1ns/1ps
module ecl_mem_model (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_rd_req,
  input wire logic [9:0] i_rd_addr,
  input wire logic [1:0] i_lat,
  output logic o_rd_valid,
  output logic [7:0] o_rd_data
);
  logic [7:0] mem [1024];
  logic [1:0] wait_r;
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      o_rd_valid <= 1'b0;
      o_rd_data <= 8'h00;
      wait_r <= 2'h0;
    end
    else if (!o_rd_valid && i_rd_req && wait_r == i_lat)
    begin
      o_rd_valid <= 1'b1;
      o_rd_data <= mem[i_rd_addr];
      wait_r <= 2'h0;
    end
    else
    begin
      o_rd_valid <= 1'b0;
      o_rd_data <= ~o_rd_data;
      wait_r <= (i_rd_req && !o_rd_valid) ? wait_r + 2'h1 : 2'h0;
    end
  end
endmodule

// ==== ecl_pkg.sv ====
// Purpose: types of the configuration image loader
// Assumes: nothing
// Notes: gray codes along the load path
package ecl_pkg;
  typedef enum logic [2:0] {
    ECL_IDLE = 3'h0,
    ECL_BASE = 3'h1,
    ECL_MAP = 3'h3,
    ECL_CHK = 3'h2,
    ECL_LOAD = 3'h6,
    ECL_DONE = 3'h7,
    ECL_ERR = 3'h5
  } ecl_state_type;
endpackage

// ==== tb_ecl_loader.sv ====
// Purpose: self-checking bench for the image loader
// Assumes: 40 MHz clock, memory model on the read side
// Notes: expected words and CRC are rebuilt from the image here
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin errors++; \
  $display("BAD %0t got %h want %h", $time, g, e); end end
module tb_ecl_loader;
  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, cfg_ready = 1'b0;
  logic [3:0] wb_adr = 4'h0, wb_sel = 4'hf;
  logic [31:0] wb_wdat = 32'h0, wb_rdat, rdat;
  logic wb_ack, rd_req, rd_valid, cfg_valid;
  logic [9:0] rd_addr, st_exp;
  logic [7:0] rd_data, cfg_addr, cfg_data, crc;
  logic [3:0] cfg_chan;
  logic [1:0] lat = 2'h0;
  logic [15:0] stat_exp;
  logic [19:0] got_q[$], exp_q[$];
  int errors = 0, samples_checked = 0, cycles = 0, hold_end = 0;
  always #12.5 i_clk = ~i_clk;
  ecl_loader dut_u (.i_clk(i_clk), .i_reset(i_reset), .i_wb_cyc(wb_cyc), .i_wb_stb(wb_stb),
    .i_wb_we(wb_we), .i_wb_adr(wb_adr), .i_wb_sel(wb_sel), .i_wb_dat(wb_wdat),
    .o_wb_dat(wb_rdat), .o_wb_ack(wb_ack), .o_rd_req(rd_req), .o_rd_addr(rd_addr),
    .i_rd_valid(rd_valid), .i_rd_data(rd_data), .o_cfg_valid(cfg_valid),
    .i_cfg_ready(cfg_ready), .o_cfg_chan(cfg_chan), .o_cfg_addr(cfg_addr),
    .o_cfg_data(cfg_data));
  ecl_mem_model mem_u (.i_clk(i_clk), .i_reset(i_reset), .i_rd_req(rd_req),
    .i_rd_addr(rd_addr), .i_lat(lat), .o_rd_valid(rd_valid), .o_rd_data(rd_data));
  task automatic stop_test;
    if (errors == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // consumer: stalls until cycle hold_end, then takes every other cycle
  always @(posedge i_clk)
  begin
    cycles <= cycles + 1;
    cfg_ready <= (cycles >= hold_end) && !cfg_ready;
    if (cfg_valid && cfg_ready)
      got_q.push_back({cfg_chan, cfg_addr, cfg_data});
    if (cycles == 40000)
    begin
      errors = errors + 1;
      stop_test();
    end
  end
  function automatic logic [7:0] crc_step(logic [7:0] c, logic [7:0] b);
    logic [7:0] x;
    x = c ^ b;
    for (int i = 0; i < 8; i++)
      x = x[7] ? {x[6:0], 1'b0} ^ 8'h07 : {x[6:0], 1'b0};
    return x;
  endfunction
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_wdat <= d;
    do
    begin
      @(posedge i_clk);
      n++;
    end
    while (wb_ack !== 1'b1);
    `CHK(n, 2)
    rdat = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask
  task automatic build(input logic lg, cr, mp, com, input logic [3:0] cnt, idx,
    input logic [9:0] st, input logic [7:0] burst);
    int hl, hb, ns;
    logic [9:0] p;
    hl = lg ? 12 : 8;
    hb = 3 + idx * hl;
    ns = com ? 1 : 4;
    for (int i = 0; i < 1024; i++)
      mem_u.mem[i] = 8'(i * 7 + 3);
    mem_u.mem[0] = {cr, mp, lg, 1'b0, cnt};
    mem_u.mem[1] = burst;
    mem_u.mem[2] = {7'h00, com};
    if (mp)
      mem_u.mem[hb + 1] = lg ? {6'h00, st[9:8]} : st[7:0];
    if (mp && lg)
      mem_u.mem[hb + 2] = st[7:0];
    crc = 8'hff;
    for (int i = 0; i < 3; i++)
      crc = crc_step(crc, mem_u.mem[i]);
    for (int i = 1; i < hl; i++)
      crc = crc_step(crc, mem_u.mem[hb + i]);
    exp_q = {};
    for (int s = 0; s < ns; s++)
      for (int k = 0; k < 66; k++)
      begin
        p = 10'(st + s * 66 + k);
        crc = crc_step(crc, mem_u.mem[p]);
        if (k % 2 == 1)
          exp_q.push_back({com ? 4'hf : 4'(1 << s), mem_u.mem[p - 1], mem_u.mem[p]});
      end
    if (mp)
      mem_u.mem[hb] = crc;
    stat_exp = {burst, cnt, 1'b0, cr, lg, com};
    st_exp = st;
  endtask
  task automatic run(input logic [3:0] idx, input logic [1:0] errs, input int words);
    got_q = {};
    wb(1'b1, 4'h0, {24'h0, idx, 4'h1});
    wb(1'b0, 4'h0, 32'h0);
    `CHK(rdat, {24'h0, idx, 4'h0})
    do
    begin
      wb(1'b0, 4'h4, 32'h0);
    end
    while (rdat[0] !== 1'b0);
    `CHK(rdat[3:2], errs)
    repeat (200) @(posedge i_clk);
    `CHK(got_q.size(), words)
    for (int i = 0; i < words; i++)
      `CHK(got_q[i], exp_q[i])
    if (words > 0)
    begin
      `CHK(rdat[19:0], {stat_exp, 4'h2})
      wb(1'b0, 4'hc, 32'h0);
      `CHK(rdat[9:0], st_exp)
      wb(1'b0, 4'h8, 32'h0);
      if (stat_exp[2])
        `CHK(rdat[15:0], {crc, crc})
    end
  endtask
  initial
  begin
    repeat (3) @(posedge i_clk);
    i_reset <= 1'b0;
    wb(1'b0, 4'h4, 32'h0);
    `CHK(rdat, 32'h0)
    wb(1'b0, 4'h2, 32'h0);
    `CHK(rdat, 32'h0)
    build(1'b0, 1'b1, 1'b1, 1'b0, 4'h1, 4'h1, 10'h013, 8'h20);
    lat <= 2'h3;
    hold_end = cycles + 1700;
    run(4'h1, 2'b00, 132);
    build(1'b1, 1'b1, 1'b1, 1'b1, 4'h3, 4'h2, 10'h150, 8'h08);
    lat <= 2'h0;
    run(4'h2, 2'b00, 33);
    build(1'b0, 1'b1, 1'b1, 1'b0, 4'h1, 4'h0, 10'h013, 8'h10);
    mem_u.mem[10'h018] = ~mem_u.mem[10'h018];
    lat <= 2'h1;
    run(4'h0, 2'b01, 0);
    build(1'b0, 1'b0, 1'b1, 1'b0, 4'h1, 4'h0, 10'h013, 8'h10);
    run(4'h2, 2'b10, 0);
    build(1'b0, 1'b0, 1'b0, 1'b1, 4'h0, 4'h0, 10'h003, 8'h04);
    run(4'h0, 2'b00, 33);
    wb_sel <= 4'he;
    wb(1'b1, 4'h0, 32'h000000f1);
    wb(1'b0, 4'h0, 32'h0);
    `CHK(rdat, 32'h0)
    wb(1'b0, 4'h4, 32'h0);
    `CHK(rdat[1:0], 2'b10)
    stop_test();
  end
endmodule
bind ecl_loader ecl_loader_checker chk_u (.i_clk(i_clk), .i_reset(i_reset),
  .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr),
  .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
  .o_rd_req(o_rd_req), .o_rd_addr(o_rd_addr), .i_rd_valid(i_rd_valid),
  .i_rd_data(i_rd_data), .o_cfg_valid(o_cfg_valid), .i_cfg_ready(i_cfg_ready),
  .o_cfg_chan(o_cfg_chan), .o_cfg_addr(o_cfg_addr), .o_cfg_data(o_cfg_data));
